// ==== hdl/tsw_pkg.sv ====
// constants, states and carriers of the task register and task switch unit
package tsw_pkg;

  // reset image of the task pointer
  localparam logic [15:0] TR_SEL_RST = 16'h0000;
  localparam logic [31:0] TR_BASE_RST = 32'h0000_0000;
  localparam logic [15:0] TR_LIMIT_RST = 16'hffff;
  localparam logic [15:0] TR_ATTR_RST = 16'h0000;

  // descriptor word 1 fields
  localparam int TYPE_LO = 8;
  localparam int SYS_BIT = 12;
  localparam int DPL_LO = 13;
  localparam int PRES_BIT = 15;
  localparam int GRAN_BIT = 23;
  localparam int BUSY_BIT = 9;
  localparam int ATTR_BUSY = 1;
  localparam logic [3:0] TYPE_TSS_IDLE = 4'h9;
  localparam logic [3:0] TYPE_TSS_BUSY = 4'hb;
  localparam logic [3:0] TYPE_TASK_GATE = 4'h5;
  localparam logic [19:0] TSS_MIN_LIMIT = 20'h00067;

  // selector fields
  localparam int SEL_TI = 2;
  localparam logic [2:0] SEL_LOW_ONES = 3'h7;

  // flags register field
  localparam int NT_BIT = 14;

  // state segment word indexes and probe offset
  localparam logic [4:0] W_LINK = 5'h00;
  localparam logic [4:0] W_FIRST_LOAD = 5'h07;
  localparam logic [4:0] W_FIRST_SAVE = 5'h08;
  localparam logic [4:0] W_FLAGS = 5'h09;
  localparam logic [4:0] W_LAST_SAVE = 5'h17;
  localparam logic [4:0] W_LAST_LOAD = 5'h18;
  localparam logic [31:0] TSS_TAIL_OFS = 32'h0000_0064;
  localparam logic [31:0] DESC_HI_OFS = 32'h0000_0004;
  localparam logic [4:0] PROBE_LAST = 5'h03;

  typedef enum logic [2:0] {
    OP_LTR, OP_STR, OP_JMP, OP_CALL, OP_SWINT, OP_HWINT, OP_EXC, OP_INTERRUPT_RETURN_INSTR
  } tsw_op_e;

  typedef enum logic [2:0] {F_NONE, F_GP, F_TS, F_NP, F_PF, F_SEG} tsw_fault_e;

  typedef enum logic [3:0] {
    S_IDLE, S_FIRST, S_LINKRD, S_DESC, S_CHECK, S_PROBE, S_OLDB, S_SAVE,
    S_LINKWR, S_NEWB, S_COMMIT, S_LOAD, S_QUAL
  } tsw_state_e;

  typedef struct packed {
    logic valid;
    tsw_op_e op;
    logic [15:0] operand;
    logic [1:0] current_privilege;
    logic [31:0] flags;
  } tsw_req_s;

  typedef struct packed {
    logic [31:0] gdt_base;
    logic [15:0] gdt_limit;
    logic [31:0] ldt_base;
    logic [15:0] ldt_limit;
    logic [31:0] idt_base;
    logic [15:0] idt_limit;
  } tsw_tbl_s;

  typedef struct packed {
    logic req;
    logic we;
    logic [31:0] addr;
    logic [31:0] wdata;
  } tsw_mem_s;

  typedef struct packed {
    logic valid;
    logic switched;
    logic fault;
    tsw_fault_e code;
    logic [15:0] sel;
    logic new_ctx;
  } tsw_resp_s;

  typedef struct packed {
    logic valid;
    logic [4:0] idx;
    logic [31:0] data;
  } tsw_ld_s;

  typedef struct packed {
    tsw_state_e state;
    tsw_op_e op;
    logic [1:0] current_privilege;
    logic [15:0] sel;
    logic [31:0] flags;
    logic [31:0] w0;
    logic [31:0] d1;
    logic phase;
    logic [4:0] cnt;
    logic committed;
    logic [15:0] tr_sel;
    logic [31:0] tr_base;
    logic [15:0] tr_limit;
    logic [15:0] tr_attr;
    logic ready;
    tsw_mem_s mem;
    tsw_resp_s resp;
    logic str_valid;
    logic [15:0] str_sel;
    tsw_ld_s ld;
    logic ts_set;
    logic qual_req;
  } tsw_st_s;

endpackage

// ==== hdl/tsw_task_switch.sv ====
// task register and hardware task switch sequencer
// How it works
// - task pointer keeps selector plus cached base, limit and attributes
// - only the selector is visible; cached descriptor stays internal
// - load instruction reads global descriptor, then sets selector and cache in the same cycle
// - load instruction only at privilege 0; otherwise changes only by switch
// - store instruction returns the selector at any privilege
// - reset clears selector and base, limit becomes ffff
// - task gate may sit anywhere; its selector is global, rpl ignored
// - gate jump or call needs privilege and rpl not above gate dpl
// - switch by jump/call to state descriptor or gate, or vector gate
// - interrupt return switches tasks when nested flag is set
// - new selector from operand, gate, or old segment link word
// - jump, call and soft interrupts check dpl; others skip it
// - new descriptor must be present with limit at least 67h
// - new task must be idle, or busy for interrupt return
// - old and new segments probed resident before any save
// - old busy cleared for jump and return, kept otherwise
// - return clears nested flag in saved flags copy only
// - save registers, selectors, flags copy and pointer at old base
// - call, interrupt, exception force nested flag in loaded flags
// - new busy set, or left set for interrupt return
// - after busy update the task pointer takes the new task
// - load new task state, then qualify segments in new context
// - idle type 1001b, busy type 1011b in descriptor
// - call, interrupt, exception write old selector into new link
// - fault before commit abandons switch, task pointer untouched
// - each completed switch pulses the task switched flag
`timescale 1ns/1ps

module tsw_task_switch (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire tsw_pkg::tsw_req_s req_i,
  output logic req_ready,
  input wire tsw_pkg::tsw_tbl_s tbl_i,
  output tsw_pkg::tsw_mem_s mem_o,
  input wire logic mem_ack,
  input wire logic mem_fault,
  input wire logic [31:0] mem_rdata,
  output logic [4:0] ctx_idx,
  input wire logic [31:0] ctx_rdata,
  output tsw_pkg::tsw_ld_s ld_o,
  output logic qual_req,
  input wire logic qual_ack,
  input wire logic qual_fault,
  output tsw_pkg::tsw_resp_s resp_o,
  output logic str_valid,
  output logic [15:0] current_task_selector,
  output logic task_switched_flag_set
);
  import tsw_pkg::*;

  tsw_st_s s_q;
  tsw_st_s s_d;

  // start a memory read
  function automatic tsw_st_s rd(input tsw_st_s x, input logic [31:0] a);
    tsw_st_s y;
    y = x;
    y.mem.req = 1'b1;
    y.mem.we = 1'b0;
    y.mem.addr = a;
    y.mem.wdata = 32'h0000_0000;
    return y;
  endfunction

  // start a memory write
  function automatic tsw_st_s wr(input tsw_st_s x, input logic [31:0] a,
                                 input logic [31:0] d);
    tsw_st_s y;
    y = x;
    y.mem.req = 1'b1;
    y.mem.we = 1'b1;
    y.mem.addr = a;
    y.mem.wdata = d;
    return y;
  endfunction

  // abandon or finish with a fault report
  function automatic tsw_st_s fail(input tsw_st_s x, input tsw_fault_e c,
                                   input logic [15:0] sel);
    tsw_st_s y;
    y = x;
    y.mem.req = 1'b0;
    y.qual_req = 1'b0;
    y.resp.valid = 1'b1;
    y.resp.switched = x.committed;
    y.resp.fault = 1'b1;
    y.resp.code = c;
    y.resp.sel = sel;
    y.resp.new_ctx = x.committed;
    y.committed = 1'b0;
    y.state = S_IDLE;
    return y;
  endfunction

  // descriptor address of a selector in a table
  function automatic logic [31:0] dadr(input logic [31:0] base,
                                       input logic [15:0] sel);
    return base + {16'h0000, sel[15:3], 3'h0};
  endfunction

  // selector fits inside table limit
  function automatic logic in_tbl(input logic [15:0] lim, input logic [15:0] sel);
    return {sel[15:3], SEL_LOW_ONES} <= lim;
  endfunction

  logic via_ldt;
  logic [1:0] d_dpl;
  logic [3:0] d_type;
  logic [19:0] d_lim;
  logic nest_op;
  logic [31:0] new_base;
  logic [31:0] old_hi;

  // decoded fields of the descriptor being handled
  always_comb begin
    via_ldt = s_q.sel[SEL_TI];
    d_dpl = mem_rdata[DPL_LO +: 2];
    d_type = mem_rdata[TYPE_LO +: 4];
    d_lim = {s_q.d1[19:16], s_q.w0[15:0]};
    nest_op = (s_q.op == OP_CALL) || (s_q.op == OP_SWINT) || (s_q.op == OP_HWINT) ||
              (s_q.op == OP_EXC);
    new_base = {s_q.d1[31:24], s_q.d1[7:0], s_q.w0[31:16]};
    old_hi = {s_q.tr_base[31:24], s_q.tr_attr, s_q.tr_base[23:16]};
  end

  // sequencer next state
  always_comb begin
    s_d = s_q;
    s_d.resp.valid = 1'b0;
    s_d.str_valid = 1'b0;
    s_d.ld.valid = 1'b0;
    s_d.ts_set = 1'b0;
    case (s_q.state)
      S_IDLE: begin
        s_d.ready = 1'b1;
        if (req_i.valid && s_q.ready) begin
          s_d.ready = 1'b0;
          s_d.op = req_i.op;
          s_d.current_privilege = req_i.current_privilege;
          s_d.sel = req_i.operand;
          s_d.flags = req_i.flags;
          s_d.phase = 1'b0;
          s_d.committed = 1'b0;
          s_d.resp.switched = 1'b0;
          s_d.resp.fault = 1'b0;
          s_d.resp.code = F_NONE;
          s_d.resp.new_ctx = 1'b0;
          s_d.resp.sel = req_i.operand;
          case (req_i.op)
            OP_STR: begin
              s_d.str_valid = 1'b1;
              s_d.str_sel = s_q.tr_sel;
              s_d.resp.valid = 1'b1;
            end
            OP_LTR: begin
              if (req_i.current_privilege != 2'h0 || req_i.operand[SEL_TI] ||
                  !in_tbl(tbl_i.gdt_limit, req_i.operand)) begin
                s_d = fail(s_d, F_GP, req_i.operand);
              end else begin
                s_d = rd(s_d, dadr(tbl_i.gdt_base, req_i.operand));
                s_d.state = S_DESC;
              end
            end
            OP_JMP, OP_CALL: begin
              if (req_i.operand[SEL_TI] ? !in_tbl(tbl_i.ldt_limit, req_i.operand) :
                  !in_tbl(tbl_i.gdt_limit, req_i.operand)) begin
                s_d = fail(s_d, F_GP, req_i.operand);
              end else begin
                s_d = rd(s_d, dadr(req_i.operand[SEL_TI] ? tbl_i.ldt_base :
                                   tbl_i.gdt_base, req_i.operand));
                s_d.state = S_FIRST;
              end
            end
            OP_SWINT, OP_HWINT, OP_EXC: begin
              if (!in_tbl(tbl_i.idt_limit, {req_i.operand[12:0], 3'h0})) begin
                s_d = fail(s_d, F_GP, req_i.operand);
              end else begin
                s_d = rd(s_d, tbl_i.idt_base + {16'h0000, req_i.operand[12:0], 3'h0});
                s_d.sel = {req_i.operand[12:0], 3'h0};
                s_d.state = S_FIRST;
              end
            end
            OP_INTERRUPT_RETURN_INSTR: begin
              if (!req_i.flags[NT_BIT]) begin
                s_d.resp.valid = 1'b1;
              end else begin
                s_d.flags[NT_BIT] = 1'b0;
                s_d = rd(s_d, s_q.tr_base);
                s_d.state = S_LINKRD;
              end
            end
            default: s_d.resp.valid = 1'b1;
          endcase
        end
      end
      S_FIRST, S_DESC: begin
        if (mem_ack && mem_fault) begin
          s_d = fail(s_q, F_PF, s_q.sel);
        end else if (mem_ack && !s_q.phase) begin
          s_d.w0 = mem_rdata;
          s_d.phase = 1'b1;
          s_d = rd(s_d, s_q.mem.addr + DESC_HI_OFS);
        end else if (mem_ack) begin
          s_d.phase = 1'b0;
          s_d.mem.req = 1'b0;
          s_d.d1 = mem_rdata;
          s_d.state = S_CHECK;
          if (s_q.state == S_FIRST && d_type == TYPE_TASK_GATE && !mem_rdata[SYS_BIT]) begin
            if (!mem_rdata[PRES_BIT]) begin
              s_d = fail(s_q, F_NP, s_q.sel);
            end else if ((s_q.op == OP_JMP || s_q.op == OP_CALL) &&
                         (s_q.current_privilege > d_dpl || s_q.sel[1:0] > d_dpl)) begin
              s_d = fail(s_q, F_GP, s_q.sel);
            end else if (s_q.op == OP_SWINT && s_q.current_privilege > d_dpl) begin
              s_d = fail(s_q, F_GP, s_q.sel);
            end else if (s_q.w0[16 + SEL_TI] || !in_tbl(tbl_i.gdt_limit, s_q.w0[31:16])) begin
              s_d = fail(s_q, F_GP, s_q.w0[31:16]);
            end else begin
              s_d.sel = {s_q.w0[31:18], 2'h0};
              s_d = rd(s_d, dadr(tbl_i.gdt_base, s_q.w0[31:16]));
              s_d.state = S_DESC;
            end
          end else if (s_q.state == S_FIRST &&
                       (s_q.op == OP_SWINT || s_q.op == OP_HWINT || s_q.op == OP_EXC ||
                        via_ldt)) begin
            s_d = fail(s_q, F_GP, s_q.sel);
          end else if (s_q.state == S_FIRST && (s_q.current_privilege > d_dpl || s_q.sel[1:0] > d_dpl)) begin
            s_d = fail(s_q, F_GP, s_q.sel);
          end
        end
      end
      S_LINKRD: begin
        if (mem_ack && mem_fault) begin
          s_d = fail(s_q, F_PF, s_q.tr_sel);
        end else if (mem_ack) begin
          s_d.sel = mem_rdata[15:0];
          if (mem_rdata[SEL_TI] || !in_tbl(tbl_i.gdt_limit, mem_rdata[15:0])) begin
            s_d = fail(s_q, F_TS, mem_rdata[15:0]);
          end else begin
            s_d = rd(s_d, dadr(tbl_i.gdt_base, mem_rdata[15:0]));
            s_d.state = S_DESC;
          end
        end
      end
      S_CHECK: begin
        if (s_q.d1[SYS_BIT] || (s_q.d1[TYPE_LO +: 4] != TYPE_TSS_IDLE &&
                                s_q.d1[TYPE_LO +: 4] != TYPE_TSS_BUSY)) begin
          s_d = fail(s_q, (s_q.op == OP_INTERRUPT_RETURN_INSTR) ? F_TS : F_GP, s_q.sel);
        end else if (!s_q.d1[PRES_BIT]) begin
          s_d = fail(s_q, F_NP, s_q.sel);
        end else if (!s_q.d1[GRAN_BIT] && d_lim < TSS_MIN_LIMIT) begin
          s_d = fail(s_q, F_TS, s_q.sel);
        end else if ((s_q.op == OP_INTERRUPT_RETURN_INSTR) != s_q.d1[BUSY_BIT]) begin
          s_d = fail(s_q, (s_q.op == OP_INTERRUPT_RETURN_INSTR) ? F_TS : F_GP, s_q.sel);
        end else if (s_q.op == OP_LTR) begin
          s_d.state = S_COMMIT;
        end else begin
          s_d.cnt = 5'h00;
          s_d = rd(s_d, s_q.tr_base);
          s_d.state = S_PROBE;
        end
      end
      S_PROBE: begin
        if (mem_ack && mem_fault) begin
          s_d = fail(s_q, F_PF, s_q.cnt[1] ? s_q.sel : s_q.tr_sel);
        end else if (mem_ack && s_q.cnt == PROBE_LAST) begin
          s_d.mem.req = 1'b0;
          s_d.state = S_OLDB;
        end else if (mem_ack) begin
          s_d.cnt = s_q.cnt + 5'h01;
          // next probe: old base, old tail, new base, new tail
          s_d = rd(s_d, ((s_q.cnt[1:0] != 2'h0) ? new_base : s_q.tr_base) +
                        (s_q.cnt[0] ? 32'h0000_0000 : TSS_TAIL_OFS));
        end
      end
      S_OLDB: begin
        if (!s_q.mem.req && (s_q.op == OP_JMP || s_q.op == OP_INTERRUPT_RETURN_INSTR)) begin
          s_d = wr(s_d, dadr(tbl_i.gdt_base, s_q.tr_sel) + DESC_HI_OFS,
                   old_hi & ~(32'h1 << BUSY_BIT));
        end else if (!s_q.mem.req || mem_ack) begin
          s_d.mem.req = 1'b0;
          s_d.cnt = W_FIRST_SAVE;
          s_d.state = S_SAVE;
          if (mem_ack && mem_fault) begin
            s_d = fail(s_q, F_PF, s_q.tr_sel);
          end
        end
      end
      S_SAVE: begin
        if (!s_q.mem.req) begin
          s_d = wr(s_d, s_q.tr_base + {25'h0, s_q.cnt, 2'h0},
                   (s_q.cnt == W_FLAGS) ? s_q.flags : ctx_rdata);
        end else if (mem_ack && mem_fault) begin
          s_d = fail(s_q, F_PF, s_q.tr_sel);
        end else if (mem_ack) begin
          s_d.mem.req = 1'b0;
          s_d.cnt = s_q.cnt + 5'h01;
          if (s_q.cnt == W_LAST_SAVE) begin
            s_d.state = nest_op ? S_LINKWR : S_NEWB;
          end
        end
      end
      S_LINKWR: begin
        if (!s_q.mem.req) begin
          s_d = wr(s_d, new_base, {16'h0000, s_q.tr_sel});
        end else if (mem_ack && mem_fault) begin
          s_d = fail(s_q, F_PF, s_q.sel);
        end else if (mem_ack) begin
          s_d.mem.req = 1'b0;
          s_d.state = S_NEWB;
        end
      end
      S_NEWB: begin
        if (!s_q.mem.req && s_q.op != OP_INTERRUPT_RETURN_INSTR) begin
          s_d.d1[BUSY_BIT] = 1'b1;
          s_d = wr(s_d, dadr(tbl_i.gdt_base, s_q.sel) + DESC_HI_OFS,
                   s_q.d1 | (32'h1 << BUSY_BIT));
        end else if (!s_q.mem.req || mem_ack) begin
          s_d.mem.req = 1'b0;
          s_d.state = S_COMMIT;
          if (mem_ack && mem_fault) begin
            s_d = fail(s_q, F_PF, s_q.sel);
          end
        end
      end
      S_COMMIT: begin
        s_d.tr_sel = s_q.sel;
        s_d.tr_base = new_base;
        s_d.tr_limit = s_q.w0[15:0];
        s_d.tr_attr = s_q.d1[23:8];
        if (s_q.op == OP_LTR) begin
          s_d.resp.valid = 1'b1;
          s_d.state = S_IDLE;
        end else begin
          s_d.committed = 1'b1;
          s_d.ts_set = 1'b1;
          s_d.cnt = W_FIRST_LOAD;
          s_d = rd(s_d, new_base + {25'h0, W_FIRST_LOAD, 2'h0});
          s_d.state = S_LOAD;
        end
      end
      S_LOAD: begin
        if (mem_ack && mem_fault) begin
          s_d = fail(s_q, F_PF, s_q.sel);
        end else if (mem_ack) begin
          s_d.ld.valid = 1'b1;
          s_d.ld.idx = s_q.cnt;
          s_d.ld.data = mem_rdata;
          if (s_q.cnt == W_FLAGS && nest_op) begin
            s_d.ld.data[NT_BIT] = 1'b1;
          end
          s_d.cnt = s_q.cnt + 5'h01;
          s_d = rd(s_d, new_base + {25'h0, s_q.cnt + 5'h01, 2'h0});
          if (s_q.cnt == W_LAST_LOAD) begin
            s_d.mem.req = 1'b0;
            s_d.state = S_QUAL;
          end
        end
      end
      S_QUAL: begin
        if (!s_q.qual_req) begin
          s_d.qual_req = 1'b1;
        end else if (qual_ack && qual_fault) begin
          s_d = fail(s_q, F_SEG, s_q.sel);
        end else if (qual_ack) begin
          s_d.qual_req = 1'b0;
          s_d.resp.valid = 1'b1;
          s_d.resp.switched = 1'b1;
          s_d.committed = 1'b0;
          s_d.state = S_IDLE;
        end
      end
      default: s_d.state = S_IDLE;
    endcase
  end

  // state register, reset image of the task pointer
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
      s_q.state <= S_IDLE;
      s_q.tr_sel <= TR_SEL_RST;
      s_q.tr_base <= TR_BASE_RST;
      s_q.tr_limit <= TR_LIMIT_RST;
      s_q.tr_attr <= TR_ATTR_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from the state register
  assign req_ready = s_q.ready;
  assign mem_o = s_q.mem;
  assign ctx_idx = s_q.cnt;
  assign ld_o = s_q.ld;
  assign qual_req = s_q.qual_req;
  assign resp_o = s_q.resp;
  assign str_valid = s_q.str_valid;
  assign current_task_selector = s_q.str_sel;
  assign task_switched_flag_set = s_q.ts_set;

endmodule

// ==== tb/tsw_mem_model.sv ====
// memory partner holding descriptor tables and state segments
`timescale 1ns/1ps
module tsw_mem_model (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire tsw_pkg::tsw_mem_s mem_i,
  input wire logic [3:0] wait_cyc,
  input wire logic [31:0] fault_addr,
  output logic mem_ack,
  output logic mem_fault,
  output logic [31:0] mem_rdata
);
  import tsw_pkg::*;
  logic [31:0] m [0:1023];
  logic [3:0] cnt_q;
  initial foreach (m[i]) m[i] = 32'h0;
  // one access at a time, answered after wait_cyc idle cycles
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 4'h0;
      mem_ack <= 1'b0;
      mem_fault <= 1'b0;
      mem_rdata <= 32'h0;
    end else if (mem_ack || !mem_i.req || cnt_q != wait_cyc) begin
      cnt_q <= (mem_ack || !mem_i.req) ? 4'h0 : cnt_q + 4'h1;
      mem_ack <= 1'b0;
      mem_fault <= 1'b0;
      mem_rdata <= ~mem_rdata; // no stale data between answers
    end else begin
      cnt_q <= 4'h0;
      mem_ack <= 1'b1;
      mem_fault <= mem_i.addr == fault_addr;
      mem_rdata <= m[mem_i.addr[11:2]];
      if (mem_i.we && mem_i.addr != fault_addr) m[mem_i.addr[11:2]] <= mem_i.wdata;
    end
  end
endmodule

// ==== tb/tsw_task_switch_asserts.sv ====
// port checker of the task switch unit
`timescale 1ns/1ps
module tsw_task_switch_asserts (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire tsw_pkg::tsw_req_s req_i,
  input wire logic req_ready,
  input wire tsw_pkg::tsw_mem_s mem_o,
  input wire logic mem_ack,
  input wire tsw_pkg::tsw_ld_s ld_o,
  input wire logic qual_req,
  input wire tsw_pkg::tsw_resp_s resp_o,
  input wire logic str_valid,
  input wire logic task_switched_flag_set
);
  import tsw_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  logic take;
  // request accepted this edge
  assign take = req_i.valid && req_ready;
  a_store_answer: assert property (
    take && req_i.op == OP_STR |=> str_valid && resp_o.valid)
    else $error("store answer missing");
  a_load_priv: assert property (
    take && req_i.op == OP_LTR && req_i.current_privilege != 2'h0
    |=> resp_o.valid && resp_o.fault && !task_switched_flag_set)
    else $error("load at low privilege not refused");
  a_plain_return: assert property (
    take && req_i.op == OP_INTERRUPT_RETURN_INSTR && !req_i.flags[NT_BIT]
    |=> resp_o.valid && !resp_o.switched && !task_switched_flag_set)
    else $error("return without nested flag switched");
  a_ready_drop: assert property (
    take |=> !req_ready)
    else $error("ready after accept");
  a_resp_ready: assert property (
    resp_o.valid |=> req_ready && !resp_o.valid)
    else $error("response not one cycle");
  a_mem_hold: assert property (
    mem_o.req && !mem_ack |=> mem_o.req && $stable(mem_o.addr) && $stable(mem_o.we)
    && $stable(mem_o.wdata))
    else $error("memory request changed before ack");
  a_idle_quiet: assert property (
    req_ready |-> !mem_o.req && !qual_req)
    else $error("activity while idle");
  a_ts_pulse: assert property (
    task_switched_flag_set |=> !task_switched_flag_set && !req_ready)
    else $error("switched flag pulse wrong");
  a_load_first: assert property (
    ld_o.valid |-> !qual_req)
    else $error("qualify before state load");
endmodule
bind tsw_task_switch tsw_task_switch_asserts u_chk (.sys_clk(sys_clk), .rst_n(rst_n),
  .req_i(req_i), .req_ready(req_ready), .mem_o(mem_o), .mem_ack(mem_ack), .ld_o(ld_o),
  .qual_req(qual_req), .resp_o(resp_o), .str_valid(str_valid),
  .task_switched_flag_set(task_switched_flag_set));

// ==== tb/tsw_task_switch_bench.sv ====
// self-checking bench of the task switch unit
`timescale 1ns/1ps
`define CHK(a, b) begin \
  checked++; \
  if ((a) !== (b)) begin \
    n_mismatch++; \
    $display("mismatch %0t: got %h want %h", $time, (a), (b)); \
  end \
end
module tsw_task_switch_bench;
  import tsw_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  tsw_req_s req_i = '0;
  tsw_tbl_s tbl_i = '{32'h0, 16'h3f, 32'h0, 16'h0, 32'h100, 16'h7f};
  logic req_ready, mem_ack, mem_fault, qual_req, str_valid, ts_set;
  logic qual_ack = 1'b0;
  logic qual_fault = 1'b0;
  logic [3:0] wait_cyc = 4'h0;
  logic [31:0] fault_addr = 32'hffff_fff0;
  logic [31:0] mem_rdata, ctx_rdata, ld_flags;
  logic [4:0] ctx_idx;
  logic [15:0] cur_sel;
  tsw_mem_s mem_o;
  tsw_ld_s ld_o;
  tsw_resp_s resp_o;
  int n_mismatch = 0;
  int checked = 0;
  int n_ts = 0;
  always #2.5 sys_clk = ~sys_clk;
  // core register image: each word tells its own index
  assign ctx_rdata = {16'hc0a0, 11'h0, ctx_idx};
  // core qualifies at once; monitors for pulses
  always @(negedge sys_clk) begin
    qual_ack <= qual_req && !qual_ack;
    if (ts_set) n_ts++;
    if (ld_o.valid && ld_o.idx == W_FLAGS) ld_flags = ld_o.data;
  end
  tsw_task_switch dut (.sys_clk(sys_clk), .rst_n(rst_n), .req_i(req_i), .req_ready(req_ready),
    .tbl_i(tbl_i), .mem_o(mem_o), .mem_ack(mem_ack), .mem_fault(mem_fault),
    .mem_rdata(mem_rdata), .ctx_idx(ctx_idx), .ctx_rdata(ctx_rdata), .ld_o(ld_o),
    .qual_req(qual_req), .qual_ack(qual_ack), .qual_fault(qual_fault), .resp_o(resp_o),
    .str_valid(str_valid), .current_task_selector(cur_sel), .task_switched_flag_set(ts_set));
  tsw_mem_model mem (.sys_clk(sys_clk), .rst_n(rst_n), .mem_i(mem_o), .wait_cyc(wait_cyc),
    .fault_addr(fault_addr), .mem_ack(mem_ack), .mem_fault(mem_fault), .mem_rdata(mem_rdata));
  task automatic tally_and_finish;
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // one request, held until taken, then wait for the answer
  task automatic run(input tsw_op_e o, input logic [15:0] s, input logic [1:0] c,
    input logic [31:0] f);
    int n;
    while (req_ready !== 1'b1) @(negedge sys_clk);
    req_i <= '{1'b1, o, s, c, f};
    n_ts = 0;
    @(negedge sys_clk);
    req_i.valid <= 1'b0;
    for (n = 0; n < 3000 && resp_o.valid !== 1'b1; n++) @(negedge sys_clk);
    `CHK(resp_o.valid, 1'b1)
    if (resp_o.valid !== 1'b1) tally_and_finish;
  endtask
  task automatic str_chk(input logic [15:0] want);
    run(OP_STR, 16'h0, 2'h3, 32'h0);
    `CHK(str_valid, 1'b1)
    `CHK(cur_sel & 16'hfff8, want)
  endtask
  // descriptor pair at a word index
  task automatic desc(input int w, input logic [31:0] lo, input logic [3:0] t,
    input logic [1:0] d, input logic p);
    mem.m[w] = lo;
    mem.m[w + 1] = {16'h0, p, d, 1'b0, t, 8'h0};
  endtask
  task automatic t_basic;
    `CHK(req_ready, 1'b1)
    str_chk(16'h0);
    run(OP_INTERRUPT_RETURN_INSTR, 16'h0, 2'h0, 32'h2);
    `CHK(resp_o.switched, 1'b0)
    run(OP_LTR, 16'h08, 2'h3, 32'h2);
    `CHK(resp_o.fault, 1'b1)
    str_chk(16'h0);
    run(OP_LTR, 16'h08, 2'h0, 32'h2);
    `CHK(resp_o.fault, 1'b0)
    str_chk(16'h08);
    $display("test basic done");
  endtask
  task automatic t_jmp;
    mem.m[3] = 32'h0000_8b00;
    run(OP_JMP, 16'h10, 2'h0, 32'h46);
    `CHK(resp_o.switched, 1'b1)
    `CHK(n_ts, 1)
    `CHK(mem.m[3][11:8], TYPE_TSS_IDLE)
    `CHK(mem.m[5][11:8], TYPE_TSS_BUSY)
    `CHK(mem.m['h109], 32'h46)
    `CHK(mem.m['h10a], 32'hc0a0_000a)
    `CHK(mem.m['h117], 32'hc0a0_0017)
    `CHK(mem.m['h140], 32'h0)
    `CHK(ld_flags[NT_BIT], 1'b0)
    str_chk(16'h10);
    $display("test jump done");
  endtask
  task automatic t_call;
    wait_cyc = 4'h3;
    run(OP_CALL, 16'h23, 2'h3, 32'h2);
    wait_cyc = 4'h0;
    `CHK(resp_o.switched, 1'b1)
    `CHK(mem.m[5][11:8], TYPE_TSS_BUSY)
    `CHK(mem.m[3][11:8], TYPE_TSS_BUSY)
    `CHK(mem.m['h100], 32'h10)
    `CHK(ld_flags[NT_BIT], 1'b1)
    str_chk(16'h08);
    run(OP_INTERRUPT_RETURN_INSTR, 16'h0, 2'h0, 32'h4002);
    `CHK(resp_o.switched, 1'b1)
    `CHK(mem.m[3][11:8], TYPE_TSS_IDLE)
    `CHK(mem.m[5][11:8], TYPE_TSS_BUSY)
    `CHK(mem.m['h109], 32'h2)
    str_chk(16'h10);
    $display("test call and return done");
  endtask
  task automatic t_fault;
    logic [15:0] sels [5] = '{16'h18, 16'h28, 16'h10, 16'h08, 16'h08};
    logic [1:0] cpls [5] = '{2'h0, 2'h0, 2'h0, 2'h3, 2'h0};
    tsw_fault_e codes [5] = '{F_TS, F_NP, F_GP, F_GP, F_PF};
    for (int i = 0; i < 5; i++) begin
      if (i == 4) fault_addr = 32'h464;
      run(OP_JMP, sels[i], cpls[i], 32'h2);
      `CHK(resp_o.code, codes[i])
      `CHK(resp_o.sel, sels[i])
      `CHK(resp_o.new_ctx, 1'b0)
      `CHK(n_ts, 0)
      `CHK(mem.m[5][11:8], TYPE_TSS_BUSY)
    end
    fault_addr = 32'hffff_fff0;
    str_chk(16'h10);
    $display("test faults done");
  endtask
  task automatic t_int;
    mem.m['h100] = 32'h0;
    run(OP_SWINT, 16'h2, 2'h3, 32'h2);
    `CHK(resp_o.code, F_GP)
    run(OP_HWINT, 16'h2, 2'h3, 32'h2);
    `CHK(resp_o.switched, 1'b1)
    `CHK(mem.m['h100], 32'h10)
    `CHK(ld_flags[NT_BIT], 1'b1)
    run(OP_EXC, 16'h2, 2'h3, 32'h2);
    `CHK(resp_o.code, F_GP)
    // return to the linked task, core refuses a new segment
    qual_fault = 1'b1;
    run(OP_INTERRUPT_RETURN_INSTR, 16'h0, 2'h0, 32'h4002);
    qual_fault = 1'b0;
    `CHK(resp_o.code, F_SEG)
    `CHK(resp_o.new_ctx, 1'b1)
    `CHK(n_ts, 1)
    str_chk(16'h10);
    $display("test interrupts done");
  endtask
  // reset, table setup, then the scenarios
  initial begin
    repeat (10) @(negedge sys_clk);
    rst_n = 1'b1;
    desc(2, 32'h0400_0067, TYPE_TSS_IDLE, 2'h0, 1'b1);
    desc(4, 32'h0500_00ff, TYPE_TSS_IDLE, 2'h0, 1'b1);
    desc(6, 32'h0600_0066, TYPE_TSS_IDLE, 2'h0, 1'b1);
    desc(8, 32'h000b_0000, TYPE_TASK_GATE, 2'h3, 1'b1);
    desc(10, 32'h0600_00ff, TYPE_TSS_IDLE, 2'h0, 1'b0);
    desc('h44, 32'h0008_0000, TYPE_TASK_GATE, 2'h0, 1'b1);
    mem.m['h149] = 32'h2;
    @(negedge sys_clk);
    t_basic;
    t_jmp;
    t_call;
    t_fault;
    t_int;
    tally_and_finish;
  end
  // hang guard
  initial begin
    #300000;
    n_mismatch++;
    tally_and_finish;
  end
endmodule
